// ===== logic/lpc_front_pkg.sv
// Purpose: Shared constants for the low-pin-count host port front end
// Assumes: Bus clock 10 MHz, one byte per bus cycle
// Notes: Timing counts derived from printed times
package lpc_front_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int ACCESS_READY_US = 100;
  localparam int ALL_READY_MS = 30;
  localparam int ACCESS_READY_CYC = (ACCESS_READY_US * 1000) / CLK_PERIOD_NS;
  localparam int ALL_READY_CYC = (ALL_READY_MS * 1000000) / CLK_PERIOD_NS;
  localparam logic [3:0] START_LOCALITY = 4'h5;
  localparam logic [3:0] START_LEGACY = 4'h0;
  localparam logic [3:0] CYC_IO_READ = 4'h0;
  localparam logic [3:0] CYC_IO_WRITE = 4'h2;
  localparam logic [3:0] SYNC_READY = 4'h0;
  localparam logic [3:0] SYNC_LONG_WAIT = 4'h6;
  localparam logic [3:0] TAR_DRIVE = 4'hF;
  localparam logic [15:0] PORT_PAIR_HIGH = 16'h007E;
  localparam logic [15:0] PORT_PAIR_LOW = 16'h00EE;
  localparam logic [11:0] ACCESS_REG_OFS = 12'h000;
  localparam logic [11:0] ACCESS_REG_MASK = 12'h0FF;
  localparam int VALID_FLAG_BIT = 7;
  localparam logic [7:0] ACCESS_RESET = 8'h80;
  localparam logic [7:0] REG_NOT_READY = 8'hFF;
  localparam logic [7:0] GPIO_DIR_RESET = 8'h00;
endpackage : lpc_front_pkg

// ===== logic/ready_timer.sv
// Purpose: Counts cycles after the init event and flags readiness
// Assumes: restart pulses or levels from same clock domain
// Notes: Restarts on each init event
`timescale 1ns/1ns
module ready_timer #(
  parameter int COUNT = 100,
  parameter int W = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic restart,
  output logic ready
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic ready_nxt;
  localparam logic [W-1:0] LAST = W'(COUNT - 1);

  assign cnt_nxt = restart ? '0 : (ready ? cnt_r : cnt_r + W'(1));
  assign ready_nxt = !restart && (ready || cnt_r == LAST);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      ready <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ready <= ready_nxt;
    end
  end
endmodule : ready_timer

// ===== logic/lpc_front.sv
// Purpose: Bus-side cycle engine, reset readiness and strap capture
// Assumes: LAD pins and frame come from the bus clock domain pins
// Notes: Register contents beyond the access register are an internal port
//
// Operation
// - Multi-byte fields arrive most significant byte first
// - Access register valid within 100 us
// - Never complete access read before valid
// - Other registers valid within 30 ms
// - Accept commands, set valid flag by 30 ms
// - Clock-run stop/restart protocol may be used
// - Address strap sampled: high 7E/7F, low EE/EF
// - Physical presence input is active high
// - Mgmt pins default high, others default low; GPIO is left undriven in test mode
// - Test strap high enables test mode
// - Locality cycles start 0101, type 0010/0000
`timescale 1ns/1ns
module lpc_front #(
  parameter int ACCESS_CYC = lpc_front_pkg::ACCESS_READY_CYC,
  parameter int ALL_CYC = lpc_front_pkg::ALL_READY_CYC
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic FRAME_B,
  input wire logic [3:0] LAD_IN,
  output logic [3:0] LAD_OUT,
  output logic LAD_OE,
  input wire logic BASE_ADDRESS_STRAP,
  input wire logic TEST_MODE_STRAP,
  input wire logic PHYSICAL_PRESENCE_INPUT,
  input wire logic CLKRUN_B_IN,
  output logic CLKRUN_B_OUT,
  output logic CLKRUN_OE,
  input wire logic KEEP_CLOCK,
  output logic MGMT_BUS_CLOCK_PIN_OUT,
  output logic MGMT_BUS_CLOCK_PIN_OE,
  output logic MGMT_BUS_DATA_PIN_OUT,
  output logic MGMT_BUS_DATA_PIN_OE,
  output logic GPIO_OUT,
  output logic GPIO_OE,
  output logic TEST_MODE,
  output logic PRESENCE,
  output logic PORT_ALT,
  output logic REGISTER_VALID_FLAG,
  output logic CMD_READY,
  output logic WR_STROBE,
  output logic WR_LOCALITY,
  output logic [15:0] WR_ADDR,
  output logic [7:0] WR_DATA,
  output logic [31:0] FIELD_WORD,
  input wire logic [7:0] REG_RD_DATA
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [3:0] lad_s1_r, lad_r;
  logic frame_s1_r, frame_b_r;
  logic [2:0] strap_s1_r, strap_r;
  logic clkrun_s1_r, clkrun_b_r;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      lad_s1_r <= 4'hF;
      lad_r <= 4'hF;
      frame_s1_r <= 1'b1;
      frame_b_r <= 1'b1;
      strap_s1_r <= 3'h0;
      strap_r <= 3'h0;
      // Clock-run pin idles high
      clkrun_s1_r <= 1'b1;
      clkrun_b_r <= 1'b1;
    end else begin
      lad_s1_r <= LAD_IN;
      lad_r <= lad_s1_r;
      frame_s1_r <= FRAME_B;
      frame_b_r <= frame_s1_r;
      strap_s1_r <= {BASE_ADDRESS_STRAP, TEST_MODE_STRAP, PHYSICAL_PRESENCE_INPUT};
      strap_r <= strap_s1_r;
      clkrun_s1_r <= CLKRUN_B_IN;
      clkrun_b_r <= clkrun_s1_r;
    end
  end

  // ****************************************
  // Readiness after the init event
  // ****************************************
  logic boot_r;
  logic init_restart;
  logic access_ready;
  logic all_ready;
  assign init_restart = !boot_r;

  ready_timer #(.COUNT(ACCESS_CYC), .W(32)) u_access_timer (
    .clk(MCLK),
    .rst_b(RST_B),
    .restart(init_restart),
    .ready(access_ready)
  );
  ready_timer #(.COUNT(ALL_CYC), .W(32)) u_all_timer (
    .clk(MCLK),
    .rst_b(RST_B),
    .restart(init_restart),
    .ready(all_ready)
  );

  // ****************************************
  // Strap capture after reset release
  // ****************************************
  logic port_alt_r, test_mode_r, latched_r, boot2_r;
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      boot_r <= 1'b0;
      boot2_r <= 1'b0;
      latched_r <= 1'b0;
      port_alt_r <= 1'b0;
      test_mode_r <= 1'b0;
    end else begin
      boot_r <= 1'b1;
      // Wait until the synchronisers carry pin levels
      boot2_r <= boot_r;
      if (!latched_r && boot2_r) begin
        latched_r <= 1'b1;
        port_alt_r <= !strap_r[2];
        test_mode_r <= strap_r[1];
      end
    end
  end
  logic [15:0] port_base;
  assign port_base = port_alt_r ? lpc_front_pkg::PORT_PAIR_LOW : lpc_front_pkg::PORT_PAIR_HIGH;

  // ****************************************
  // Cycle engine
  // ****************************************
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_CYC = 4'b0001, S_ADDR = 4'b0011, S_WDATA = 4'b0010,
    S_TAR1 = 4'b0110, S_SYNC = 4'b0111, S_RDATA = 4'b0101, S_TAR2 = 4'b0100,
    S_TAR3 = 4'b1100
  } state_t;
  state_t state_r, state_nxt;
  logic [1:0] nib_r;
  logic is_write_r, locality_r;
  logic [15:0] addr_r;
  logic [7:0] data_r;

  wire start_seen = !frame_b_r;
  wire start_loc = lad_r == lpc_front_pkg::START_LOCALITY;
  wire start_leg = lad_r == lpc_front_pkg::START_LEGACY;
  wire cyc_ok = lad_r == lpc_front_pkg::CYC_IO_READ || lad_r == lpc_front_pkg::CYC_IO_WRITE;
  wire is_access = locality_r && ((addr_r[11:0] & ~lpc_front_pkg::ACCESS_REG_MASK) == lpc_front_pkg::ACCESS_REG_OFS);
  wire addr_hit = locality_r || ((addr_r & 16'hFFFE) == port_base);
  wire rd_ready = is_access ? access_ready : all_ready;
  wire [7:0] access_byte = 8'(all_ready) << lpc_front_pkg::VALID_FLAG_BIT;
  wire [7:0] rd_byte = is_access ? access_byte : REG_RD_DATA;

  always_comb begin
    state_nxt = state_r;
    if (start_seen) begin
      state_nxt = (start_loc || start_leg) ? S_CYC : S_IDLE;
    end else begin
      case (state_r)
        S_CYC: state_nxt = cyc_ok ? S_ADDR : S_IDLE;
        S_ADDR: state_nxt = (nib_r == 2'd3) ? (is_write_r ? S_WDATA : S_TAR1) : S_ADDR;
        S_WDATA: state_nxt = (nib_r == 2'd1) ? S_TAR1 : S_WDATA;
        S_TAR1: state_nxt = (nib_r == 2'd1) ? (addr_hit ? S_SYNC : S_IDLE) : S_TAR1;
        S_SYNC: state_nxt = (is_write_r ? all_ready : rd_ready) ? (is_write_r ? S_TAR2 : S_RDATA) : S_SYNC;
        // Ready sync, low nibble, high nibble
        S_RDATA: state_nxt = (nib_r == 2'd2) ? S_TAR2 : S_RDATA;
        S_TAR2: state_nxt = is_write_r ? S_TAR3 : S_IDLE;
        default: state_nxt = S_IDLE;
      endcase
    end
  end

  logic [3:0] lad_nxt;
  logic oe_nxt;
  always_comb begin
    lad_nxt = lpc_front_pkg::TAR_DRIVE;
    oe_nxt = 1'b0;
    case (state_nxt)
      S_SYNC: begin
        oe_nxt = 1'b1;
        lad_nxt = lpc_front_pkg::SYNC_LONG_WAIT;
      end
      S_RDATA: begin
        oe_nxt = 1'b1;
        lad_nxt = (nib_r == 2'd0) ? data_r[3:0] : data_r[7:4];
      end
      S_TAR2: oe_nxt = 1'b1;
      S_TAR3: oe_nxt = 1'b1;
      default: oe_nxt = 1'b0;
    endcase
    if (state_r == S_SYNC && state_nxt != S_SYNC) begin
      oe_nxt = 1'b1;
      lad_nxt = lpc_front_pkg::SYNC_READY;
    end
  end

  logic [31:0] field_r;
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= S_IDLE;
      nib_r <= 2'd0;
      is_write_r <= 1'b0;
      locality_r <= 1'b0;
      addr_r <= 16'h0000;
      data_r <= 8'h00;
      LAD_OUT <= 4'hF;
      LAD_OE <= 1'b0;
      WR_STROBE <= 1'b0;
      field_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      nib_r <= (state_nxt != state_r) ? 2'd0 : nib_r + 2'd1;
      LAD_OUT <= lad_nxt;
      LAD_OE <= oe_nxt;
      WR_STROBE <= 1'b0;
      if (start_seen) locality_r <= start_loc;
      if (state_r == S_CYC) is_write_r <= lad_r == lpc_front_pkg::CYC_IO_WRITE;
      if (state_r == S_ADDR) addr_r <= {addr_r[11:0], lad_r};
      if (state_r == S_WDATA) data_r <= {lad_r, data_r[7:4]};
      if (state_r == S_SYNC && state_nxt == S_RDATA) data_r <= rd_byte;
      if (state_r == S_SYNC && state_nxt == S_TAR2 && is_write_r) begin
        WR_STROBE <= 1'b1;
        field_r <= {field_r[23:0], data_r};
      end
    end
  end
  assign WR_ADDR = addr_r;
  assign WR_DATA = data_r;
  assign WR_LOCALITY = locality_r;
  assign FIELD_WORD = field_r;

  // ****************************************
  // Pins and status outputs
  // ****************************************
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      MGMT_BUS_CLOCK_PIN_OUT <= 1'b1;
      MGMT_BUS_CLOCK_PIN_OE <= 1'b1;
      MGMT_BUS_DATA_PIN_OUT <= 1'b1;
      MGMT_BUS_DATA_PIN_OE <= 1'b1;
      GPIO_OUT <= 1'b0;
      GPIO_OE <= 1'b0;
      CLKRUN_B_OUT <= 1'b0;
      CLKRUN_OE <= 1'b0;
      TEST_MODE <= 1'b0;
      PRESENCE <= 1'b0;
      PORT_ALT <= 1'b0;
      REGISTER_VALID_FLAG <= 1'b0;
      CMD_READY <= 1'b0;
    end else begin
      MGMT_BUS_CLOCK_PIN_OUT <= 1'b1;
      MGMT_BUS_CLOCK_PIN_OE <= 1'b1;
      MGMT_BUS_DATA_PIN_OUT <= 1'b1;
      MGMT_BUS_DATA_PIN_OE <= 1'b1;
      GPIO_OUT <= 1'b0;
      GPIO_OE <= latched_r && !test_mode_r;
      CLKRUN_B_OUT <= 1'b0;
      CLKRUN_OE <= clkrun_b_r && (KEEP_CLOCK || state_r != S_IDLE);
      TEST_MODE <= test_mode_r;
      PRESENCE <= strap_r[0];
      PORT_ALT <= port_alt_r;
      REGISTER_VALID_FLAG <= all_ready;
      CMD_READY <= all_ready;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_sync_wait;
    state_r == S_SYNC && !rd_ready && !is_write_r;
  endsequence
  a_sync_long_wait: assert property (@(posedge MCLK) disable iff (!RST_B)
    s_sync_wait |=> LAD_OE && LAD_OUT == lpc_front_pkg::SYNC_LONG_WAIT) else $error("no long wait");
  a_no_early_rdata: assert property (@(posedge MCLK) disable iff (!RST_B)
    state_r == S_RDATA && $past(state_r) == S_SYNC |-> $past(rd_ready)) else $error("early read");
  a_flag_follows_ready: assert property (@(posedge MCLK) disable iff (!RST_B)
    $rose(all_ready) |=> REGISTER_VALID_FLAG && CMD_READY) else $error("flag late");
  a_access_order: assert property (@(posedge MCLK) disable iff (!RST_B)
    all_ready |-> access_ready) else $error("access not first");
  a_presence_high: assert property (@(posedge MCLK) disable iff (!RST_B)
    ##1 PRESENCE == $past(strap_r[0])) else $error("presence");
  a_mgmt_high: assert property (@(posedge MCLK) disable iff (!RST_B)
    MGMT_BUS_CLOCK_PIN_OUT && MGMT_BUS_DATA_PIN_OUT && !GPIO_OUT) else $error("pin defaults");
  a_gpio_test: assert property (@(posedge MCLK) disable iff (!RST_B)
    TEST_MODE |-> !GPIO_OE) else $error("gpio in test");
  a_cyc_type: assert property (@(posedge MCLK) disable iff (!RST_B)
    state_r == S_CYC && !start_seen && !cyc_ok |=> state_r == S_IDLE) else $error("bad type");
  sequence s_ready_sync;
    state_r == S_RDATA && nib_r == 2'd0 && LAD_OE && LAD_OUT == lpc_front_pkg::SYNC_READY;
  endsequence
  sequence s_data_nibbles;
    LAD_OE && LAD_OUT == data_r[3:0] ##1 LAD_OE && LAD_OUT == data_r[7:4];
  endsequence
  a_read_nibbles: assert property (@(posedge MCLK) disable iff (!RST_B)
    s_ready_sync |=> s_data_nibbles) else $error("read nibbles");
  a_write_tar: assert property (@(posedge MCLK) disable iff (!RST_B)
    state_r == S_TAR3 |-> LAD_OE && LAD_OUT == lpc_front_pkg::TAR_DRIVE) else $error("write tar");
  a_strap_sample: assert property (@(posedge MCLK) disable iff (!RST_B)
    $rose(latched_r) |-> port_alt_r == !$past(strap_r[2]) && test_mode_r == $past(strap_r[1]))
    else $error("strap sample");
endmodule : lpc_front

// ===== dv/lpc_host_model.sv
// Purpose: Host controller model for the low-pin-count port
// Assumes: Drives on the falling edge; LAD pulled up when released
// Notes: Waits for the ready sync under a bounded count
`timescale 1ns/1ns
module lpc_host_model (
  input wire logic mclk,
  input wire logic [3:0] lad_out,
  input wire logic lad_oe,
  output logic frame_b,
  output logic [3:0] lad_in
);
  logic [3:0] host_nib = 4'hF;
  logic host_oe = 1'b0;
  // ****************
  // Wire resolution
  // ****************
  assign lad_in = lad_oe ? lad_out : (host_oe ? host_nib : 4'hF);
  initial frame_b = 1'b1;
  task automatic put(input logic [3:0] n);
    @(negedge mclk);
    host_oe = 1'b1;
    host_nib = n;
  endtask : put
  // One byte per cycle; wide fields are split by the caller, MSB first
  task automatic xfer(input logic [3:0] start, input logic wr, input logic [15:0] addr,
      input logic [7:0] wdat, output logic [7:0] rdat, output int waits);
    int n;
    waits = 0;
    rdat = 8'h00;
    put(start);
    frame_b = 1'b0;
    put(wr ? lpc_front_pkg::CYC_IO_WRITE : lpc_front_pkg::CYC_IO_READ);
    frame_b = 1'b1;
    for (n = 3; n >= 0; n--) put(addr[4*n +: 4]);
    if (wr) begin
      put(wdat[3:0]);
      put(wdat[7:4]);
    end
    put(4'hF);
    @(negedge mclk);
    host_oe = 1'b0;
    n = 0;
    while (!(lad_oe && lad_out === lpc_front_pkg::SYNC_READY) && n < 600) begin
      if (lad_oe && lad_out === lpc_front_pkg::SYNC_LONG_WAIT) waits++;
      n++;
      @(negedge mclk);
    end
    if (n >= 600) waits = -1;
    if (!wr) begin
      @(negedge mclk);
      rdat[3:0] = lad_out;
      @(negedge mclk);
      rdat[7:4] = lad_out;
    end
    repeat (3) @(negedge mclk);
  endtask : xfer
endmodule : lpc_host_model

// ===== dv/lpc_front_test.sv
// Purpose: Self-checking bench for lpc_front
// Assumes: Timers shortened to 20 and 100 cycles
// Notes: Host model issues wide fields byte by byte
`timescale 1ns/1ns
module lpc_front_test;
  localparam int ACC = 20;
  localparam int ALL = 100;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic frame_b, lad_oe, clkrun_out, clkrun_oe, mgc_out, mgc_oe, mgd_out, mgd_oe;
  logic gpio_out, gpio_oe, test_mode, presence, port_alt, valid_flag, cmd_ready, wr_strobe, wr_loc;
  logic [3:0] lad_in, lad_out;
  logic addr_strap = 1'b1;
  logic test_strap = 1'b0;
  logic presence_in = 1'b1;
  logic keep_clock = 1'b0;
  logic host_clkrun_b = 1'b1;
  logic [15:0] wr_addr, last_addr;
  logic [7:0] wr_data, rd, last_data;
  logic last_loc;
  logic [31:0] field_word;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int rel = 0;
  int waits;
  always #50 mclk = ~mclk;
  lpc_host_model i_lpc_host_model (.mclk(mclk), .lad_out(lad_out), .lad_oe(lad_oe), .frame_b(frame_b),
    .lad_in(lad_in));
  lpc_front #(.ACCESS_CYC(ACC), .ALL_CYC(ALL)) i_lpc_front (.MCLK(mclk), .RST_B(rst_b), .FRAME_B(frame_b),
    .LAD_IN(lad_in), .LAD_OUT(lad_out), .LAD_OE(lad_oe), .BASE_ADDRESS_STRAP(addr_strap),
    .TEST_MODE_STRAP(test_strap), .PHYSICAL_PRESENCE_INPUT(presence_in),
    .CLKRUN_B_IN(clkrun_oe ? clkrun_out : host_clkrun_b), .CLKRUN_B_OUT(clkrun_out), .CLKRUN_OE(clkrun_oe),
    .KEEP_CLOCK(keep_clock), .MGMT_BUS_CLOCK_PIN_OUT(mgc_out), .MGMT_BUS_CLOCK_PIN_OE(mgc_oe),
    .MGMT_BUS_DATA_PIN_OUT(mgd_out), .MGMT_BUS_DATA_PIN_OE(mgd_oe), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe),
    .TEST_MODE(test_mode), .PRESENCE(presence), .PORT_ALT(port_alt), .REGISTER_VALID_FLAG(valid_flag),
    .CMD_READY(cmd_ready), .WR_STROBE(wr_strobe), .WR_LOCALITY(wr_loc), .WR_ADDR(wr_addr),
    .WR_DATA(wr_data), .FIELD_WORD(field_word), .REG_RD_DATA(8'hA5));
  // ****************
  // Checking helpers
  // ****************
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (wr_strobe === 1'b1) begin
      last_addr <= wr_addr;
      last_data <= wr_data;
      last_loc <= wr_loc;
    end
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task reset_cycle;
    @(negedge mclk);
    rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    check(lad_oe, 1'b0);
    check({mgc_out, mgc_oe, mgd_out, mgd_oe}, 4'hF);
    check(gpio_out, 1'b0);
    repeat (3) @(negedge mclk);
    rst_b = 1'b1;
    rel = cyc;
    $display("test reset done");
  endtask : reset_cycle
  task t_access_early;
    i_lpc_host_model.xfer(lpc_front_pkg::START_LOCALITY, 1'b0, 16'h0000, 8'h00, rd, waits);
    check(waits > 0, 1'b1);
    check(rd, 8'h00);
    check(cyc - rel <= ACC + 20, 1'b1);
    $display("test access done");
  endtask : t_access_early
  task t_straps(input logic [3:0] exp);
    repeat (5) @(negedge mclk);
    check(port_alt, exp[3]);
    check(test_mode, exp[2]);
    check(gpio_oe, exp[1]);
    check(presence, exp[0]);
    $display("test straps done");
  endtask : t_straps
  task t_ready_and_regs;
    while (cyc - rel < ALL + 4) @(negedge mclk);
    check({valid_flag, cmd_ready}, 2'b11);
    i_lpc_host_model.xfer(lpc_front_pkg::START_LOCALITY, 1'b0, 16'h0F18, 8'h00, rd, waits);
    check(rd, 8'hA5);
    i_lpc_host_model.xfer(lpc_front_pkg::START_LOCALITY, 1'b0, 16'h0000, 8'h00, rd, waits);
    check(rd, 8'h01 << lpc_front_pkg::VALID_FLAG_BIT);
    $display("test ready done");
  endtask : t_ready_and_regs
  task t_field;
    logic [31:0] fld;
    fld = 32'h00051234;
    for (int i = 0; i < 4; i++)
      i_lpc_host_model.xfer(lpc_front_pkg::START_LOCALITY, 1'b1, 16'h0F24 + 16'(i), fld[31-8*i -: 8], rd, waits);
    check(field_word, fld);
    check({last_loc, last_addr}, {1'b1, 16'h0F27});
    i_lpc_host_model.xfer(lpc_front_pkg::START_LEGACY, 1'b1, lpc_front_pkg::PORT_PAIR_HIGH, 8'h3C, rd, waits);
    check({last_loc, last_addr, last_data}, {1'b0, lpc_front_pkg::PORT_PAIR_HIGH, 8'h3C});
    $display("test field done");
  endtask : t_field
  task t_clkrun;
    repeat (4) @(negedge mclk);
    keep_clock = 1'b1;
    @(negedge mclk);
    check({clkrun_oe, clkrun_out}, 2'b10);
    // Host answers by holding the pin low
    host_clkrun_b = 1'b0;
    repeat (4) @(negedge mclk);
    check(clkrun_oe, 1'b0);
    keep_clock = 1'b0;
    host_clkrun_b = 1'b1;
    repeat (4) @(negedge mclk);
    check(clkrun_oe, 1'b0);
    $display("test clkrun done");
  endtask : t_clkrun
  initial begin
    reset_cycle();
    t_access_early();
    t_straps(4'b0011);
    t_ready_and_regs();
    t_field();
    t_clkrun();
    addr_strap = 1'b0;
    test_strap = 1'b1;
    presence_in = 1'b0;
    reset_cycle();
    t_straps(4'b1100);
    final_report();
  end
endmodule : lpc_front_test
